//--- logic/tgs_gate_timer.sv
// tgs_gate_timer.sv: 16-bit timer with selectable, polarity-controlled gate sources
// assumes: instruction clock i_ref_clk, sources synchronous to it, avalon-mm master
//
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tgs_defs.svh"
module tgs_gate_timer #(
   parameter int COUNT_WIDTH = 16
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // register bus
   input wire tgs_pkg::tgs_req_s i_bus,
   output tgs_pkg::tgs_rsp_s o_bus,
   // gate sources
   input wire tgs_pkg::tgs_src_s i_src,
   // state
   output logic [COUNT_WIDTH-1:0] o_count,
   output logic o_gate_value
);
   import tgs_pkg::*;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] timer_control_reg;
   logic [7:0] timer_control_next;
   logic [7:0] timer_gate_control_reg;
   logic [7:0] timer_gate_control_next;
   logic [7:0] period_reg;
   logic [7:0] period_next;
   logic [COUNT_WIDTH-1:0] count_reg;
   logic [COUNT_WIDTH-1:0] count_next;
   logic gate_reg;
   logic gate_next;
   tgs_bus_e bus_reg;
   tgs_bus_e bus_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic [7:0] t2_count;
   logic t2_pulse;
   logic [7:0] cmp_status;
   logic gate_raw;
   logic gate_pol;
   logic count_en;
   logic req;
   logic wr_take;

   // ----------------------------------------
   // second timer
   // ----------------------------------------
   tgs_second_timer #(
      .WIDTH(8)
   )
   u_t2 (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_enable(timer_control_reg[`TGS_TC_T2ON_BIT]),
      .i_period(period_reg),
      .o_count(t2_count),
      .o_match_pulse(t2_pulse)
   );

   // ----------------------------------------
   // gate selection
   // ----------------------------------------
   always_comb
   begin
      cmp_status = 8'h00;
      cmp_status[`TGS_CMP1_BIT] = i_src.cmp_one;
      cmp_status[`TGS_CMP2_BIT] = i_src.cmp_two;
      case (timer_gate_control_reg[`TGS_GC_SS_LSB +: 2])
         `TGS_SS_PIN: gate_raw = i_src.gate_input_pin;
         `TGS_SS_T2MATCH: gate_raw = t2_pulse;
         `TGS_SS_CMP1: gate_raw = cmp_status[`TGS_CMP1_BIT];
         `TGS_SS_CMP2: gate_raw = cmp_status[`TGS_CMP2_BIT];
         default: gate_raw = 1'b0;
      endcase
      // polarity 1 counts while source is high, 0 while low
      gate_pol = timer_gate_control_reg[`TGS_GC_POL_BIT] ? gate_raw : ~gate_raw;
      // gating ignored unless gate enable is set
      count_en = timer_control_reg[`TGS_TC_ON_BIT] &&
                 (!timer_gate_control_reg[`TGS_GC_ENABLE_BIT] || gate_pol);
   end

   // ----------------------------------------
   // bus slave and counter next state
   // ----------------------------------------
   assign req = i_bus.read || i_bus.write;
   assign wr_take = i_bus.write && (bus_reg == TGS_BUS_IDLE);

   always_comb
   begin
      timer_control_next = timer_control_reg;
      timer_gate_control_next = timer_gate_control_reg;
      period_next = period_reg;
      count_next = count_reg;
      rdata_next = rdata_reg;
      bus_next = TGS_BUS_IDLE;
      gate_next = gate_pol;
      if (count_en)
      begin
         count_next = count_reg + 1'b1;
      end
      case (bus_reg)
         TGS_BUS_IDLE:
         begin
            if (req)
            begin
               bus_next = TGS_BUS_ACK;
            end
            rdata_next = 32'h0000_0000;
            case (i_bus.address)
               `TGS_ADDR_TIMER_CONTROL: rdata_next[7:0] = timer_control_reg;
               `TGS_ADDR_GATE_CONTROL:
               begin
                  rdata_next[7:0] = timer_gate_control_reg;
                  rdata_next[`TGS_GC_VAL_BIT] = gate_reg;
               end
               `TGS_ADDR_CMP_STATUS: rdata_next[7:0] = cmp_status;
               `TGS_ADDR_T2_PERIOD: rdata_next[7:0] = period_reg;
               `TGS_ADDR_T2_COUNT: rdata_next[7:0] = t2_count;
               `TGS_ADDR_T1_COUNT_LO: rdata_next[7:0] = count_reg[7:0];
               `TGS_ADDR_T1_COUNT_HI: rdata_next[7:0] = count_reg[15:8];
               default: rdata_next = 32'h0000_0000;
            endcase
            if (wr_take)
            begin
               case (i_bus.address)
                  `TGS_ADDR_TIMER_CONTROL: timer_control_next = i_bus.writedata[7:0];
                  `TGS_ADDR_GATE_CONTROL: timer_gate_control_next = i_bus.writedata[7:0];
                  `TGS_ADDR_T2_PERIOD: period_next = i_bus.writedata[7:0];
                  // software write to a count byte wins over an increment of that byte in the same cycle; the other byte keeps the increment
                  `TGS_ADDR_T1_COUNT_LO: count_next[7:0] = i_bus.writedata[7:0];
                  `TGS_ADDR_T1_COUNT_HI: count_next[15:8] = i_bus.writedata[7:0];
                  default: count_next = count_next;
               endcase
            end
         end
         TGS_BUS_ACK: bus_next = TGS_BUS_IDLE;
         default: bus_next = TGS_BUS_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         timer_control_reg <= `TGS_RST_BYTE;
         timer_gate_control_reg <= `TGS_RST_BYTE;
         period_reg <= `TGS_RST_PERIOD;
         count_reg <= `TGS_RST_COUNT;
         gate_reg <= 1'b0;
         bus_reg <= TGS_BUS_IDLE;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         timer_control_reg <= timer_control_next;
         timer_gate_control_reg <= timer_gate_control_next;
         period_reg <= period_next;
         count_reg <= count_next;
         gate_reg <= gate_next;
         bus_reg <= bus_next;
         rdata_reg <= rdata_next;
      end
   end

   // waitrequest is high except in the single ack cycle; one driver for the whole answer
   assign o_bus = '{readdata: rdata_reg, waitrequest: (bus_reg != TGS_BUS_ACK)};
   assign o_count = count_reg;
   assign o_gate_value = gate_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic quiet;
   assign quiet = timer_control_reg[`TGS_TC_ON_BIT] && !wr_take;
   property p_match_pol1;
      @(posedge i_ref_clk) disable iff (i_reset)
      (quiet && timer_gate_control_reg[7:6] == 2'b11 &&
       timer_gate_control_reg[1:0] == `TGS_SS_T2MATCH)
      |=> (count_reg == $past(count_reg) + $past(t2_pulse));
   endproperty
   a_match_pol1: assert property (p_match_pol1) else $error("pol1 match count");
   property p_match_pol0;
      @(posedge i_ref_clk) disable iff (i_reset)
      (quiet && timer_gate_control_reg[7:6] == 2'b10 &&
       timer_gate_control_reg[1:0] == `TGS_SS_T2MATCH)
      |=> (count_reg == $past(count_reg) + !$past(t2_pulse));
   endproperty
   a_match_pol0: assert property (p_match_pol0) else $error("pol0 match count");
   property p_cmp1;
      @(posedge i_ref_clk) disable iff (i_reset)
      (quiet && timer_gate_control_reg[7:6] == 2'b11 &&
       timer_gate_control_reg[1:0] == `TGS_SS_CMP1 && !i_src.cmp_one) |=> $stable(count_reg);
   endproperty
   a_cmp1: assert property (p_cmp1) else $error("cmp1 low yet counting");
   property p_cmp2;
      @(posedge i_ref_clk) disable iff (i_reset)
      (quiet && timer_gate_control_reg[7:6] == 2'b11 &&
       timer_gate_control_reg[1:0] == `TGS_SS_CMP2 && i_src.cmp_two)
      |=> (count_reg == $past(count_reg) + 1'b1);
   endproperty
   a_cmp2: assert property (p_cmp2) else $error("cmp2 high yet idle");
   property p_ungated;
      @(posedge i_ref_clk) disable iff (i_reset)
      (quiet && !timer_gate_control_reg[`TGS_GC_ENABLE_BIT])
      |=> (count_reg == $past(count_reg) + 1'b1);
   endproperty
   a_ungated: assert property (p_ungated) else $error("ungated not counting");
   property p_pin_pol;
      @(posedge i_ref_clk) disable iff (i_reset)
      (timer_gate_control_reg[1:0] == `TGS_SS_PIN)
      |=> (gate_reg == ($past(i_src.gate_input_pin) == $past(timer_gate_control_reg[6])));
   endproperty
   a_pin_pol: assert property (p_pin_pol) else $error("pin polarity");
   property p_ack;
      @(posedge i_ref_clk) disable iff (i_reset)
      (req && bus_reg == TGS_BUS_IDLE) |=> !o_bus.waitrequest ##1 o_bus.waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack timing");
   c_pol1: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      timer_gate_control_reg[7:6] == 2'b11 && t2_pulse && count_en);
   c_cmp1: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      timer_gate_control_reg[1:0] == `TGS_SS_CMP1 && count_en);
   c_read: cover property (@(posedge i_ref_clk) disable iff (i_reset)
      i_bus.read && !o_bus.waitrequest);
endmodule
`default_nettype wire

//--- logic/tgs_defs.svh
// tgs_defs.svh: register offsets, field positions and reset values of the timer gate block
// assumes: included by bare name from the package and the design files
`ifndef TGS_DEFS_SVH
`define TGS_DEFS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define TGS_ADDR_TIMER_CONTROL 4'h0
`define TGS_ADDR_GATE_CONTROL 4'h1
`define TGS_ADDR_CMP_STATUS 4'h2
`define TGS_ADDR_T2_PERIOD 4'h3
`define TGS_ADDR_T2_COUNT 4'h4
`define TGS_ADDR_T1_COUNT_LO 4'h5
`define TGS_ADDR_T1_COUNT_HI 4'h6
// ----------------------------------------
// fields
// ----------------------------------------
`define TGS_TC_ON_BIT 0
`define TGS_TC_T2ON_BIT 1
`define TGS_GC_ENABLE_BIT 7
`define TGS_GC_POL_BIT 6
`define TGS_GC_VAL_BIT 2
`define TGS_GC_SS_LSB 0
`define TGS_CMP1_BIT 6
`define TGS_CMP2_BIT 7
// ----------------------------------------
// reset values and encodings
// ----------------------------------------
`define TGS_RST_BYTE 8'h00
`define TGS_RST_PERIOD 8'hff
`define TGS_RST_COUNT 16'h0000
`define TGS_SS_PIN 2'h0
`define TGS_SS_T2MATCH 2'h1
`define TGS_SS_CMP1 2'h2
`define TGS_SS_CMP2 2'h3
`endif

//--- logic/tgs_pkg.sv
// tgs_pkg.sv: types shared by the timer gate block
// assumes: tgs_defs.svh is on the include path
`include "tgs_defs.svh"
package tgs_pkg;
   // ----------------------------------------
   // avalon request and answer
   // ----------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [3:0] address;
      logic [31:0] writedata;
   } tgs_req_s;
   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } tgs_rsp_s;
   // ----------------------------------------
   // inputs the gate chooses among
   // ----------------------------------------
   typedef struct packed {
      logic gate_input_pin;
      logic cmp_one;
      logic cmp_two;
   } tgs_src_s;
   typedef enum logic [1:0]
   {
      TGS_BUS_IDLE = 2'b01,
      TGS_BUS_ACK = 2'b10
   } tgs_bus_e;
endpackage

//--- logic/tgs_second_timer.sv
// tgs_second_timer.sv: 8-bit second timer with period match and one-cycle gate pulse
// assumes: one clock, synchronous active-high reset, increments every cycle when enabled except on a period match, which loads zero
`timescale 1ns/1ps
`default_nettype none
`include "tgs_defs.svh"
module tgs_second_timer #(
   parameter int WIDTH = 8
)
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // control
   input wire logic i_enable,
   input wire logic [WIDTH-1:0] i_period,
   // state
   output logic [WIDTH-1:0] o_count,
   output logic o_match_pulse
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;
   logic pulse_reg;
   logic pulse_next;

   always_comb
   begin
      count_next = count_reg;
      pulse_next = 1'b0;
      if (i_enable)
      begin
         if (count_reg == i_period)
         begin
            count_next = '0;
            pulse_next = 1'b1;
         end
         else
         begin
            count_next = count_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
      begin
         count_reg <= '0;
         pulse_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         pulse_reg <= pulse_next;
      end
   end

   assign o_count = count_reg;
   assign o_match_pulse = pulse_reg;

   property p_wrap_zero;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_enable && count_reg == i_period) |=> (count_reg == '0);
   endproperty
   a_wrap_zero: assert property (p_wrap_zero) else $error("no wrap to zero");
   property p_pulse_one;
      @(posedge i_ref_clk) disable iff (i_reset)
      pulse_reg |-> (count_reg == '0) ##1 !pulse_reg || (i_period == '0);
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse not one cycle");
   property p_count_up;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_enable && count_reg != i_period) |=> (count_reg == $past(count_reg) + 1'b1);
   endproperty
   a_count_up: assert property (p_count_up) else $error("no increment");
   c_wrap: cover property (@(posedge i_ref_clk) disable iff (i_reset) pulse_reg);
endmodule
`default_nettype wire

//--- verif/tgs_src_model.sv
// tgs_src_model.sv: far-side model of the gate sources (pin and both comparators)
// assumes: the bench asks for levels; they reach the block one clock later, synchronous
`timescale 1ns/1ps
`default_nettype none
module tgs_src_model
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset,
   // requested levels
   input wire tgs_pkg::tgs_src_s i_levels,
   // levels seen by the block
   output tgs_pkg::tgs_src_s o_src
);
   import tgs_pkg::*;
   // ----------------------------------------
   // source levels
   // ----------------------------------------
   // registered so a level never changes in the block's sampling step
   always_ff @(posedge i_ref_clk)
   begin
      if (i_reset)
         o_src <= '0;
      else
         o_src <= i_levels;
   end
endmodule
`default_nettype wire

//--- verif/timer_gate_source_select_tb_top.sv
// timer_gate_source_select_tb_top.sv: self-checking bench of the timer gate block
// assumes: tgs_defs.svh on the include path; one 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "tgs_defs.svh"
module timer_gate_source_select_tb_top;
   import tgs_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic i_ref_clk = 1'b0;
   logic i_reset = 1'b1;
   tgs_req_s i_bus = '0;
   tgs_rsp_s o_bus;
   tgs_src_s levels = '0;
   tgs_src_s src;
   logic [15:0] o_count;
   logic o_gate_value;
   int num_errors = 0;
   int checked = 0;
   always #12.5 i_ref_clk = ~i_ref_clk;
   tgs_src_model model (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_levels(levels),
      .o_src(src));
   tgs_gate_timer dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_bus(i_bus),
      .o_bus(o_bus), .i_src(src), .o_count(o_count), .o_gate_value(o_gate_value));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one request held until waitrequest is seen low; the wait is bounded
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_bus <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
      // answer taken at the rising edge, before that edge updates the slave
      do
      begin
         @(posedge i_ref_clk);
         n++;
         if (n > 20)
         begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, 1'b1, 1'b0);
            report_and_stop();
         end
      end
      while (o_bus.waitrequest !== 1'b0);
      q = o_bus.readdata;
      i_bus <= '0;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(q, {24'h0, exp});
   endtask
   // count increments and gate highs seen over n settled cycles
   task automatic measure(input int n, output logic [15:0] inc, output int highs);
      logic [15:0] c0;
      highs = 0;
      @(negedge i_ref_clk);
      c0 = o_count;
      repeat (n)
      begin
         if (o_gate_value === 1'b1)
            highs++;
         @(negedge i_ref_clk);
      end
      inc = o_count - c0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset_regs();
      // polarity 0 with the pin low passes the gate, so the gate value bit reads set
      logic [7:0] exp [0:7] = '{8'h00, 8'h04, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int a = 0; a < 8; a++)
         rd_chk(4'(a), exp[a]);
      wr(4'h7, 8'h5a);
      rd_chk(4'h7, 8'h00);
      wr(`TGS_ADDR_T1_COUNT_LO, 8'h34);
      wr(`TGS_ADDR_T1_COUNT_HI, 8'h12);
      rd_chk(`TGS_ADDR_T1_COUNT_LO, 8'h34);
      rd_chk(`TGS_ADDR_T1_COUNT_HI, 8'h12);
      $display("test reset_regs done");
   endtask
   task automatic test_free_run();
      logic [15:0] inc;
      int h;
      levels <= '0;
      wr(`TGS_ADDR_GATE_CONTROL, 8'h41);
      wr(`TGS_ADDR_TIMER_CONTROL, 8'h01);
      measure(10, inc, h);
      chk(inc, 16'd10);
      $display("test free_run done");
   endtask
   task automatic test_level_sources();
      logic [1:0] ss [0:2] = '{`TGS_SS_PIN, `TGS_SS_CMP1, `TGS_SS_CMP2};
      logic [15:0] inc;
      logic g;
      int h;
      for (int i = 0; i < 3; i++)
         for (int p = 0; p < 2; p++)
            for (int l = 0; l < 2; l++)
            begin
               // unselected sources sit opposite, so a wrong choice shows
               @(posedge i_ref_clk);
               levels <= '{gate_input_pin: (i == 0) ~^ l[0], cmp_one: (i == 1) ~^ l[0],
                  cmp_two: (i == 2) ~^ l[0]};
               wr(`TGS_ADDR_GATE_CONTROL, {1'b1, p[0], 4'h0, ss[i]});
               g = p[0] ? l[0] : !l[0];
               measure(10, inc, h);
               chk(inc, g ? 16'd10 : 16'd0);
               chk(o_gate_value, g);
               if (i > 0)
                  rd_chk(`TGS_ADDR_CMP_STATUS, {levels.cmp_two, levels.cmp_one, 6'h0});
            end
      $display("test level_sources done");
   endtask
   task automatic test_period_match();
      logic [15:0] inc;
      logic [31:0] q;
      int h;
      wr(`TGS_ADDR_T2_PERIOD, 8'h03);
      wr(`TGS_ADDR_TIMER_CONTROL, 8'h03);
      for (int p = 0; p < 2; p++)
      begin
         wr(`TGS_ADDR_GATE_CONTROL, {1'b1, p[0], 4'h0, `TGS_SS_T2MATCH});
         measure(16, inc, h);
         chk(inc, p ? 16'd4 : 16'd12);
         chk(h, p ? 4 : 12);
         bus(1'b0, `TGS_ADDR_T2_COUNT, 8'h00, q);
         chk(q <= 32'h3, 1'b1);
      end
      wr(`TGS_ADDR_GATE_CONTROL, {2'b10, 4'h0, `TGS_SS_T2MATCH});
      measure(16, inc, h);
      chk(inc, 16'd12);
      $display("test period_match done");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      repeat (4) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      test_reset_regs();
      test_free_run();
      test_level_sources();
      test_period_match();
      report_and_stop();
   end
endmodule
`default_nettype wire
